/* File: drs_reset_seq.sv */
// Device reset sequencer: main power-good, global reset, clock enable,
// boot start, pin overrides during reset, clock bypass in deepest idle,
// separate real-time-clock power-on reset and power-lost flag.
// Assumes analog detector levels are synchronous to core_clk.
//
// Summary of operation
// - Global reset when pin low or supply bad.
// - Supply ok after 8ms, 4ms, above 900mV.
// - Global reset spares the real-time-clock domain.
// - Boot starts when global reset releases.
// - Clock generator enabled before boot proceeds.
// - RTC power-on sets power-lost flag.
// - Deepest idle bypasses generator via clock select.
// - Reset overrides pins: high, low, Z, clock.
// - Software resets are not hardware resets.
module drs_reset_seq #(
  parameter int unsigned BG_CYCLES  = drs_pkg::ANA_BG_CYCLES,
  parameter int unsigned SUP_CYCLES = drs_pkg::ANA_SUP_CYCLES
) (
  // Clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    rst,
  // Reset pin and analog detectors
  input  wire logic                    reset_pin_n,
  input  wire logic                    analog_regulator_input,
  input  wire logic                    analog_supply_on,
  input  wire logic [11:0]             core_regulator_output,
  // Real-time-clock domain
  input  wire logic                    rtc_power_on,
  input  wire logic                    rtc_flag_clear,
  output logic                         rtc_power_lost_flag,
  output logic                         rtc_reset_n,
  // Software reset requests
  input  wire logic                    cpu_soft_reset,
  input  wire logic [7:0]              periph_soft_reset,
  output logic                         cpu_reset_n,
  output logic [7:0]                   periph_reset_n,
  // Sequencing outputs
  output logic                         supply_ok_signal,
  output logic                         global_reset_n,
  output logic                         clkgen_enable,
  output logic                         boot_start,
  // Clock bypass
  input  wire logic                    deepest_idle_state,
  input  wire logic                    ref_clk_select,
  output logic                         clk_bypass,
  output logic                         clk_src_rtc,
  // Pin overrides
  input  wire logic [drs_pkg::HI_W-1:0]  hi_func,
  input  wire logic [drs_pkg::LO_W-1:0]  lo_func,
  input  wire logic [drs_pkg::Z_W-1:0]   z_func,
  input  wire logic [drs_pkg::Z_W-1:0]   z_func_oe,
  input  wire logic [drs_pkg::S01_W-1:0] s01_func,
  input  wire logic [drs_pkg::S10_W-1:0] s10_func,
  input  wire logic [drs_pkg::SX1_W-1:0] sx1_func,
  input  wire logic [drs_pkg::SX0_W-1:0] sx0_func,
  output logic [drs_pkg::HI_W-1:0]       hi_pin,
  output logic [drs_pkg::LO_W-1:0]       lo_pin,
  output logic [drs_pkg::Z_W-1:0]        z_pin,
  output logic [drs_pkg::Z_W-1:0]        z_pin_oe,
  output logic                           clk_pin_sel,
  output logic [drs_pkg::S01_W-1:0]      s01_pin,
  output logic [drs_pkg::S10_W-1:0]      s10_pin,
  output logic [drs_pkg::SX1_W-1:0]      sx1_pin,
  output logic [drs_pkg::SX0_W-1:0]      sx0_pin
);

  ////////////////////////////////////////////////////////////////////////
  logic bg_ok;
  logic sup_ok;
  logic v_ok;
  logic grst_n;

  drs_settle_timer #(.CYCLES(BG_CYCLES)) u_bg_tmr (
    .core_clk (core_clk),
    .rst      (rst),
    .level_in (analog_regulator_input),
    .settled  (bg_ok)
  );

  drs_settle_timer #(.CYCLES(SUP_CYCLES)) u_sup_tmr (
    .core_clk (core_clk),
    .rst      (rst),
    .level_in (analog_supply_on),
    .settled  (sup_ok)
  );

  assign v_ok = core_regulator_output > drs_pkg::CORE_THRESH_MV;

  ////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic                       pg;
    logic                       grst_n;
    logic [1:0]                 low_cnt;
    logic [1:0]                 clk_cnt;
    drs_pkg::drs_state_t        state;
    logic                       clken;
    logic                       boot;
    logic                       rtc_lost;
    logic                       rtc_rst_n;
    logic                       cpu_rst_n;
    logic [7:0]                 per_rst_n;
    logic                       bypass;
    logic                       src_rtc;
    logic [drs_pkg::HI_W-1:0]   hi;
    logic [drs_pkg::LO_W-1:0]   lo;
    logic [drs_pkg::Z_W-1:0]    z;
    logic [drs_pkg::Z_W-1:0]    z_oe;
    logic                       clk_sel;
    logic [drs_pkg::S01_W-1:0]  s01;
    logic [drs_pkg::S10_W-1:0]  s10;
    logic [drs_pkg::SX1_W-1:0]  sx1;
    logic [drs_pkg::SX0_W-1:0]  sx0;
  } drs_regs_t;

  drs_regs_t st_ff;
  drs_regs_t nxt_st;

  // Pin low must stand three clocks before it counts; tied high never does
  logic pin_low_ok;
  assign pin_low_ok = (st_ff.low_cnt == 2'(drs_pkg::RST_MIN_CYCLES - 1))
                      && !reset_pin_n;
  assign grst_n = !(pin_low_ok || !st_ff.pg);

  always_comb begin
    nxt_st = st_ff;
    nxt_st.pg = bg_ok && sup_ok && v_ok;
    if (reset_pin_n) begin
      nxt_st.low_cnt = drs_pkg::RST_CNT_W0;
    end else if (!pin_low_ok) begin
      nxt_st.low_cnt = st_ff.low_cnt + 2'h1;
    end
    // Once recognised, reset holds while the pin stays low
    nxt_st.grst_n = grst_n && !(!reset_pin_n && !st_ff.grst_n);
    nxt_st.boot = 1'b0;
    case (st_ff.state)
      drs_pkg::DRS_HELD: begin
        nxt_st.clken = 1'b0;
        if (st_ff.grst_n) begin
          nxt_st.state   = drs_pkg::DRS_CLK_EN;
          nxt_st.clken   = 1'b1;
          nxt_st.clk_cnt = drs_pkg::CLK_SETTLE_CNT;
        end
      end
      drs_pkg::DRS_CLK_EN: begin
        nxt_st.clk_cnt = st_ff.clk_cnt - 2'h1;
        if (st_ff.clk_cnt == 2'h1) begin
          nxt_st.state = drs_pkg::DRS_BOOT;
          nxt_st.boot  = 1'b1;
        end
      end
      drs_pkg::DRS_BOOT: begin
      end
      default: nxt_st.state = drs_pkg::DRS_HELD;
    endcase
    if (!st_ff.grst_n) begin
      nxt_st.state = drs_pkg::DRS_HELD;
      nxt_st.clken = 1'b0;
      nxt_st.boot  = 1'b0;
    end
    // Real-time-clock domain ignores global reset; own power-on only
    nxt_st.rtc_rst_n = !rtc_power_on;
    if (rtc_power_on) begin
      nxt_st.rtc_lost = 1'b1;
    end else if (rtc_flag_clear) begin
      nxt_st.rtc_lost = 1'b0;
    end
    // Software resets never drive global reset
    nxt_st.cpu_rst_n = st_ff.grst_n && !cpu_soft_reset;
    nxt_st.per_rst_n = {8{st_ff.grst_n}} & ~periph_soft_reset;
    nxt_st.bypass  = deepest_idle_state;
    nxt_st.src_rtc = ref_clk_select;
    if (!st_ff.grst_n) begin
      nxt_st.hi      = '1;
      nxt_st.lo      = '0;
      nxt_st.z       = '0;
      nxt_st.z_oe    = '0;
      nxt_st.clk_sel = 1'b1;
      nxt_st.s01     = '0;
      nxt_st.s10     = '1;
      nxt_st.sx1     = '0;
      nxt_st.sx0     = '0;
    end else if (st_ff.state == drs_pkg::DRS_HELD) begin
      // First clock after release: go to second listed level
      nxt_st.s01 = '1;
      nxt_st.s10 = '0;
      nxt_st.sx1 = '1;
      nxt_st.sx0 = '0;
    end else begin
      nxt_st.hi      = hi_func;
      nxt_st.lo      = lo_func;
      nxt_st.z       = z_func;
      nxt_st.z_oe    = z_func_oe;
      nxt_st.clk_sel = 1'b0;
      nxt_st.s01     = s01_func;
      nxt_st.s10     = s10_func;
      nxt_st.sx1     = sx1_func;
      nxt_st.sx0     = sx0_func;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_ff           <= '0;
      st_ff.state     <= drs_pkg::DRS_HELD;
      st_ff.rtc_lost  <= 1'b1;
      st_ff.hi        <= '1;
      st_ff.s10       <= '1;
      st_ff.clk_sel   <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign supply_ok_signal    = st_ff.pg;
  assign global_reset_n      = st_ff.grst_n;
  assign clkgen_enable       = st_ff.clken;
  assign boot_start          = st_ff.boot;
  assign rtc_power_lost_flag = st_ff.rtc_lost;
  assign rtc_reset_n         = st_ff.rtc_rst_n;
  assign cpu_reset_n         = st_ff.cpu_rst_n;
  assign periph_reset_n      = st_ff.per_rst_n;
  assign clk_bypass          = st_ff.bypass;
  assign clk_src_rtc         = st_ff.src_rtc;
  assign hi_pin              = st_ff.hi;
  assign lo_pin              = st_ff.lo;
  assign z_pin               = st_ff.z;
  assign z_pin_oe            = st_ff.z_oe;
  assign clk_pin_sel         = st_ff.clk_sel;
  assign s01_pin             = st_ff.s01;
  assign s10_pin             = st_ff.s10;
  assign sx1_pin             = st_ff.sx1;
  assign sx0_pin             = st_ff.sx0;

  ////////////////////////////////////////////////////////////////////////
  grst_cause_a: assert property (@(posedge core_clk) disable iff (rst)
    !st_ff.pg |=> !global_reset_n)
    else $error("global reset not taken on supply loss");
  pg_cause_a: assert property (@(posedge core_clk) disable iff (rst)
    $rose(supply_ok_signal) |-> $past(bg_ok) && $past(sup_ok))
    else $error("supply ok rose before settling");
  rtc_keep_a: assert property (@(posedge core_clk) disable iff (rst)
    !global_reset_n && !rtc_flag_clear && rtc_power_lost_flag
    |=> rtc_power_lost_flag)
    else $error("rtc flag lost on global reset");
  boot_seq_a: assert property (@(posedge core_clk) disable iff (rst)
    $rose(clkgen_enable) |-> ##2 (boot_start || !global_reset_n))
    else $error("boot not started after clock enable");
  clk_first_a: assert property (@(posedge core_clk) disable iff (rst)
    boot_start |-> clkgen_enable && $past(clkgen_enable))
    else $error("boot before clock generator");
  rtc_por_a: assert property (@(posedge core_clk) disable iff (rst)
    rtc_power_on |=> rtc_power_lost_flag && !rtc_reset_n)
    else $error("rtc power-on not flagged");
  pin_min_a: assert property (@(posedge core_clk) disable iff (rst)
    $fell(global_reset_n) && supply_ok_signal
    |-> $past(!reset_pin_n, 3))
    else $error("short reset pulse recognised");
  bypass_a: assert property (@(posedge core_clk) disable iff (rst)
    deepest_idle_state |=> clk_bypass)
    else $error("clock not bypassed in deepest idle");
  pin_ovr_a: assert property (@(posedge core_clk) disable iff (rst)
    !global_reset_n |=> hi_pin == '1 && lo_pin == '0
    && z_pin_oe == '0 && clk_pin_sel)
    else $error("pins not overridden in reset");
  soft_a: assert property (@(posedge core_clk) disable iff (rst)
    cpu_soft_reset && global_reset_n && supply_ok_signal
    |=> !cpu_reset_n && global_reset_n)
    else $error("software reset treated as hardware");
  synch_a: assert property (@(posedge core_clk) disable iff (rst)
    $rose(global_reset_n) |=> s01_pin == '1 && s10_pin == '0)
    else $error("synch group did not transition");

endmodule : drs_reset_seq

/* File: drs_pkg.sv */
// Package of constants for the device reset sequencer.
// Assumes one core clock at 10 MHz; all users write drs_pkg::name.
package drs_pkg;

  localparam int unsigned CLK_PERIOD_NS   = 100;
  // Power-good settling times, as printed
  localparam int unsigned ANA_BG_TIME_MS  = 8;
  localparam int unsigned ANA_SUP_TIME_MS = 4;
  localparam int unsigned ANA_BG_CYCLES   =
    ANA_BG_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned ANA_SUP_CYCLES  =
    ANA_SUP_TIME_MS * 1000000 / CLK_PERIOD_NS;
  // Core regulator threshold in mV, compared against a digitised level
  localparam logic [11:0] CORE_THRESH_MV  = 12'h384;
  // Least reset pulse, in main core clock periods
  localparam int unsigned RST_MIN_CYCLES  = 3;
  localparam logic [1:0]  RST_CNT_W0      = 2'h0;
  // Clock enable to boot start, in cycles
  localparam logic [1:0]  CLK_SETTLE_CNT  = 2'h2;
  // Pin group widths
  localparam int unsigned HI_W            = 12;
  localparam int unsigned LO_W            = 5;
  localparam int unsigned Z_W             = 8;
  localparam int unsigned S01_W           = 3;
  localparam int unsigned S10_W           = 2;
  localparam int unsigned SX1_W           = 2;
  localparam int unsigned SX0_W           = 21;

  typedef enum logic [1:0] {
    DRS_HELD,
    DRS_CLK_EN,
    DRS_BOOT
  } drs_state_t;

endpackage : drs_pkg

/* File: drs_settle_timer.sv */
// Settling timer: output rises after input stays high for CYCLES clocks.
// Assumes a synchronous enable level; restarts whenever it falls.
module drs_settle_timer #(
  parameter int unsigned CYCLES = 16
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // Level in, settled out
  input  wire logic level_in,
  output logic      settled
);

  localparam int unsigned CW = $clog2(CYCLES + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          done;
  } drs_tmr_t;

  drs_tmr_t st_ff;
  drs_tmr_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (!level_in) begin
      nxt_st.cnt  = '0;
      nxt_st.done = 1'b0;
    end else if (st_ff.cnt == CW'(CYCLES - 1)) begin
      nxt_st.done = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt + CW'(1);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign settled = st_ff.done;

endmodule : drs_settle_timer

/* File: drs_reset_source.sv */
// Model of the board reset source that drives the external reset pin.
// Assumes the bench calls pulse() from its own thread.
module drs_reset_source (
  // Clock
  input  wire logic core_clk,
  // Reset pin, released high between pulses
  output logic      reset_pin_n
);
  timeunit 1ns;
  timeprecision 1ns;

  initial reset_pin_n = 1'b1;

  // Low for n clocks; n below three is a deliberate short pulse
  task automatic pulse(input int unsigned n);
    @(posedge core_clk);
    #1 reset_pin_n = 1'b0;
    repeat (n) @(posedge core_clk);
    #1 reset_pin_n = 1'b1;
  endtask : pulse
endmodule : drs_reset_source

/* File: drs_reset_seq_test.sv */
// Self-checking bench for the device reset sequencer.
// Assumes settling counts shortened to 8 and 4 clocks.
module drs_reset_seq_test;
  timeunit 1ns;
  timeprecision 1ns;

  logic core_clk = 1'b0, rst = 1'b1, reset_pin_n;
  logic analog_regulator_input = 1'b0, analog_supply_on = 1'b0;
  logic [11:0] core_regulator_output = 12'h384;
  logic rtc_power_on = 1'b0, rtc_flag_clear = 1'b0, cpu_soft_reset = 1'b0;
  logic [7:0] periph_soft_reset = 8'h00, periph_reset_n;
  logic deepest_idle_state = 1'b0, ref_clk_select = 1'b0;
  logic rtc_power_lost_flag, rtc_reset_n, cpu_reset_n, supply_ok_signal;
  logic global_reset_n, clkgen_enable, boot_start, clk_bypass, clk_src_rtc;
  logic [11:0] hi_func = 12'ha5c, hi_pin;
  logic [4:0]  lo_func = 5'h0a, lo_pin;
  logic [7:0]  z_func = 8'h3c, z_func_oe = 8'hf0, z_pin, z_pin_oe;
  logic [2:0]  s01_func = 3'h5, s01_pin;
  logic [1:0]  s10_func = 2'h1, sx1_func = 2'h2, s10_pin, sx1_pin;
  logic [20:0] sx0_func = 21'h0a5a5a, sx0_pin;
  logic        clk_pin_sel;
  int          errors = 0, tests_run = 0, k;

  always #50 core_clk = ~core_clk;

  drs_reset_source SRC (.core_clk(core_clk), .reset_pin_n(reset_pin_n));

  drs_reset_seq #(.BG_CYCLES(8), .SUP_CYCLES(4)) DUT (
    .core_clk(core_clk), .rst(rst), .reset_pin_n(reset_pin_n),
    .analog_regulator_input(analog_regulator_input),
    .analog_supply_on(analog_supply_on),
    .core_regulator_output(core_regulator_output),
    .rtc_power_on(rtc_power_on), .rtc_flag_clear(rtc_flag_clear),
    .rtc_power_lost_flag(rtc_power_lost_flag), .rtc_reset_n(rtc_reset_n),
    .cpu_soft_reset(cpu_soft_reset), .periph_soft_reset(periph_soft_reset),
    .cpu_reset_n(cpu_reset_n), .periph_reset_n(periph_reset_n),
    .supply_ok_signal(supply_ok_signal), .global_reset_n(global_reset_n),
    .clkgen_enable(clkgen_enable), .boot_start(boot_start),
    .deepest_idle_state(deepest_idle_state),
    .ref_clk_select(ref_clk_select), .clk_bypass(clk_bypass),
    .clk_src_rtc(clk_src_rtc), .hi_func(hi_func), .lo_func(lo_func),
    .z_func(z_func), .z_func_oe(z_func_oe), .s01_func(s01_func),
    .s10_func(s10_func), .sx1_func(sx1_func), .sx0_func(sx0_func),
    .hi_pin(hi_pin), .lo_pin(lo_pin), .z_pin(z_pin), .z_pin_oe(z_pin_oe),
    .clk_pin_sel(clk_pin_sel), .s01_pin(s01_pin), .s10_pin(s10_pin),
    .sx1_pin(sx1_pin), .sx0_pin(sx0_pin));

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Inputs move 1 ns after the edge, outputs are settled by then
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc

  task automatic wait_release;
    for (k = 0; k < 40 && global_reset_n !== 1'b1; k++) cyc(1);
    chk(global_reset_n, 1'b1);
  endtask : wait_release

  task automatic wrap_up;
    if (errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset_levels;
    chk(global_reset_n, 1'b0);
    chk(supply_ok_signal, 1'b0);
    chk(rtc_power_lost_flag, 1'b1);
    chk(clkgen_enable, 1'b0);
    chk(boot_start, 1'b0);
    chk(hi_pin, 12'hfff);
    chk(lo_pin, 5'h00);
    chk(z_pin_oe, 8'h00);
    chk(clk_pin_sel, 1'b1);
    chk(s01_pin, 3'h0);
    chk(s10_pin, 2'h3);
    chk(sx0_pin, 21'h0);
    chk(sx1_pin, 2'h0);
  endtask : t_reset_levels

  task automatic t_power_up;
    analog_regulator_input = 1'b1;
    analog_supply_on = 1'b1;
    cyc(3);
    chk(supply_ok_signal, 1'b0);
    cyc(17);
    chk(supply_ok_signal, 1'b0);
    chk(global_reset_n, 1'b0);
    core_regulator_output = 12'h385;
    wait_release();
    chk(supply_ok_signal, 1'b1);
    chk(clkgen_enable, 1'b0);
    cyc(1);
    chk(clkgen_enable, 1'b1);
    chk(boot_start, 1'b0);
    chk(s01_pin, 3'h7);
    chk(s10_pin, 2'h0);
    chk(sx1_pin, 2'h3);
    cyc(1);
    chk({hi_pin, lo_pin, z_pin_oe}, {hi_func, lo_func, z_func_oe});
    chk({z_pin, s01_pin, s10_pin}, {z_func, s01_func, s10_func});
    chk({sx1_pin, sx0_pin, clk_pin_sel}, {sx1_func, sx0_func, 1'b0});
    cyc(1);
    chk(boot_start, 1'b1);
    cyc(1);
    chk(boot_start, 1'b0);
  endtask : t_power_up

  task automatic t_rtc;
    rtc_flag_clear = 1'b1;
    cyc(1);
    chk(rtc_power_lost_flag, 1'b0);
    rtc_power_on = 1'b1;
    cyc(1);
    chk(rtc_power_lost_flag, 1'b1);
    chk(rtc_reset_n, 1'b0);
    chk(global_reset_n, 1'b1);
    rtc_power_on = 1'b0;
    cyc(2);
    rtc_flag_clear = 1'b0;
    chk(rtc_power_lost_flag, 1'b0);
    chk(rtc_reset_n, 1'b1);
  endtask : t_rtc

  task automatic t_pin_reset;
    SRC.pulse(2);
    for (int i = 0; i < 4; i++) begin
      chk(global_reset_n, 1'b1);
      cyc(1);
    end
    fork
      SRC.pulse(8);
      begin
        cyc(6);
        chk(global_reset_n, 1'b0);
        chk(hi_pin, 12'hfff);
        chk(clkgen_enable, 1'b0);
        chk(rtc_power_lost_flag, 1'b0);
      end
    join
    wait_release();
    for (k = 0; k < 6 && boot_start !== 1'b1; k++) cyc(1);
    chk(boot_start, 1'b1);
    // Exactly three low samples is the shortest pulse that counts
    SRC.pulse(3);
    chk(global_reset_n, 1'b0);
    wait_release();
  endtask : t_pin_reset

  task automatic t_supply_drop;
    analog_supply_on = 1'b0;
    // Timer drops, then supply ok, then global reset: one edge each
    cyc(2);
    chk(supply_ok_signal, 1'b0);
    cyc(1);
    chk(global_reset_n, 1'b0);
    analog_supply_on = 1'b1;
    wait_release();
  endtask : t_supply_drop

  task automatic t_soft;
    cpu_soft_reset = 1'b1;
    periph_soft_reset = 8'h81;
    cyc(1);
    chk(cpu_reset_n, 1'b0);
    chk(periph_reset_n, 8'h7e);
    chk(global_reset_n, 1'b1);
    chk(boot_start, 1'b0);
    cpu_soft_reset = 1'b0;
    periph_soft_reset = 8'h00;
    cyc(1);
    chk({cpu_reset_n, periph_reset_n}, 9'h1ff);
  endtask : t_soft

  task automatic t_idle;
    for (int i = 0; i < 2; i++) begin
      deepest_idle_state = 1'b1;
      ref_clk_select = i[0];
      cyc(1);
      chk({clk_bypass, clk_src_rtc}, {1'b1, i[0]});
    end
    deepest_idle_state = 1'b0;
    cyc(1);
    chk(clk_bypass, 1'b0);
  endtask : t_idle

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge core_clk);
    #1;
    t_reset_levels();
    rst = 1'b0;
    t_power_up();
    t_rtc();
    t_pin_reset();
    t_supply_drop();
    t_soft();
    t_idle();
    wrap_up();
  end

  // Whole run is under a hundred clocks; this is far beyond it
  initial begin
    #500000;
    errors++;
    wrap_up();
  end
endmodule : drs_reset_seq_test
